// ---- common/bitexec_cfg.svh ----
`ifndef BITEXEC_CFG_SVH
`define BITEXEC_CFG_SVH

// status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7
`define FLAGS_RESET 8'h00

// register map (byte addresses)
`define REG_OP_ADDR 12'h000
`define REG_OPERAND_ADDR 12'h004
`define REG_DATA_ADDR 12'h008
`define REG_FLAGS_ADDR 12'h00C
`define REG_PC_ADDR 12'h010
`define REG_IO_ADDR 12'h014
`define REG_STATUS_ADDR 12'h018
`define REG_GO_ADDR 12'h01C

// cycle counts
`define CYC_BRANCH_TAKEN 2'h2
`define CYC_IO_BIT 2'h2
`define CYC_SINGLE 2'h1

`endif

// ---- common/bitexec_pkg.sv ----
package bitexec_pkg;

  typedef enum logic [5:0] {
    op_nop,
    branch_same_or_higher,
    branch_unsigned_below,
    branch_on_negative,
    branch_on_positive,
    branch_signed_ge,
    branch_signed_less,
    branch_half_carry_on,
    branch_half_carry_off,
    branch_transfer_on,
    branch_irq_on,
    branch_irq_off,
    io_bit_set_op,
    io_bit_clear_op,
    shift_left_logical,
    shift_right_logical,
    rotate_left_via_carry,
    rotate_right_via_carry,
    shift_right_arith,
    nibble_exchange_op,
    status_bit_set_op,
    status_bit_clear_op,
    store_bit_to_transfer,
    load_bit_from_transfer,
    carry_flag_set_op,
    carry_flag_clear_op,
    negative_flag_set_op,
    negative_flag_clear_op,
    zero_flag_set_op,
    zero_flag_clear_op,
    global_irq_on_op
  } opcode_e;

  typedef enum {
    st_idle,
    st_exec,
    st_wait
  } exec_state_e;

  typedef struct packed {
    logic [7:0] result;
    logic [7:0] flags;
    logic [15:0] pc;
    logic io_write;
    logic io_bit_value;
    logic [1:0] cycles;
  } exec_out_s;

endpackage

// ---- core/bit_exec_core.sv ----
`timescale 1ns/1ps
`include "bitexec_cfg.svh"

module bit_exec_core (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bitexec_pkg::exec_state_e state;
    bitexec_pkg::opcode_e op;
    logic [7:0] offset_k;
    logic [2:0] bit_b;
    logic [5:0] io_addr;
    logic [7:0] data;
    logic [7:0] flags;
    logic [15:0] pc;
    logic [1:0] cycle_cnt;
    logic [1:0] last_cycles;
    logic busy;
    logic done;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_state_s;

  core_state_s cur_reg;
  core_state_s cur_next;

  // the io byte space is kept as its own array: a packed struct cannot hold memory
  logic [7:0] io_space [0:63];
  logic io_we;
  logic [7:0] io_wdata;

  logic [7:0] shift_result;
  logic [7:0] shift_flags;
  logic br_is_branch;
  logic br_taken;

  shift_unit u_shift (
    .op(cur_reg.op),
    .value(cur_reg.data),
    .flags_in(cur_reg.flags),
    .result(shift_result),
    .flags_out(shift_flags)
  );

  branch_unit u_branch (
    .op(cur_reg.op),
    .flags(cur_reg.flags),
    .is_branch(br_is_branch),
    .taken(br_taken)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx,
                                         input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction

  // k is a signed 7-bit word offset, as in the branch encoding
  function automatic logic [15:0] branch_target(input logic [15:0] pc,
                                                input logic [7:0] k);
    logic [15:0] sk;
    sk = {{9{k[6]}}, k[6:0]};
    return 16'(pc + sk + 16'h0001);
  endfunction

  function automatic logic [2:0] flag_index(input bitexec_pkg::opcode_e op,
                                            input logic [2:0] s);
    logic [2:0] r;
    r = s;
    unique case (op)
      bitexec_pkg::carry_flag_set_op, bitexec_pkg::carry_flag_clear_op: r = `FLAG_C;
      bitexec_pkg::negative_flag_set_op, bitexec_pkg::negative_flag_clear_op: r = `FLAG_N;
      bitexec_pkg::zero_flag_set_op, bitexec_pkg::zero_flag_clear_op: r = `FLAG_Z;
      bitexec_pkg::global_irq_on_op: r = `FLAG_I;
      default: r = s;
    endcase
    return r;
  endfunction

  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic [7:0] io_val;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    apb_acc = psel && penable && !cur_reg.pready;
    apb_wr = apb_acc && pwrite;
    apb_rd = apb_acc && !pwrite;
    io_val = io_space[cur_reg.io_addr];
    io_we = 1'b0;
    io_wdata = pwdata[7:0];
    cur_next.pready = apb_acc;
    cur_next.pslverr = 1'b0;
    cur_next.done = cur_reg.done;
    if (apb_rd) begin
      unique case (paddr)
        `REG_OP_ADDR: cur_next.prdata = {26'h0, cur_reg.op};
        `REG_OPERAND_ADDR:
          cur_next.prdata = {15'h0, cur_reg.io_addr, cur_reg.bit_b, cur_reg.offset_k};
        `REG_DATA_ADDR: cur_next.prdata = {24'h0, cur_reg.data};
        `REG_FLAGS_ADDR: cur_next.prdata = {24'h0, cur_reg.flags};
        `REG_PC_ADDR: cur_next.prdata = {16'h0, cur_reg.pc};
        `REG_IO_ADDR: cur_next.prdata = {24'h0, io_val};
        `REG_STATUS_ADDR:
          cur_next.prdata = {28'h0, cur_reg.last_cycles, cur_reg.done, cur_reg.busy};
        `REG_GO_ADDR: cur_next.prdata = 32'h0;
        default: begin
          cur_next.prdata = 32'h0;
          cur_next.pslverr = 1'b1;
        end
      endcase
    end
    // writes other than the status done clear are accepted only while idle so state is never torn mid-instruction
    if (apb_wr) begin
      unique case (paddr)
        `REG_OP_ADDR:
          if (!cur_reg.busy) cur_next.op = bitexec_pkg::opcode_e'(pwdata[5:0]);
        `REG_OPERAND_ADDR:
          if (!cur_reg.busy) begin
            cur_next.offset_k = pwdata[7:0];
            cur_next.bit_b = pwdata[10:8];
            cur_next.io_addr = pwdata[16:11];
          end
        `REG_DATA_ADDR: if (!cur_reg.busy) cur_next.data = pwdata[7:0];
        `REG_FLAGS_ADDR: if (!cur_reg.busy) cur_next.flags = pwdata[7:0];
        `REG_PC_ADDR: if (!cur_reg.busy) cur_next.pc = pwdata[15:0];
        `REG_IO_ADDR:
          if (!cur_reg.busy) io_we = 1'b1;
        `REG_STATUS_ADDR: cur_next.done = 1'b0;
        `REG_GO_ADDR:
          if (!cur_reg.busy && pwdata[0]) begin
            cur_next.busy = 1'b1;
            cur_next.done = 1'b0;
            cur_next.state = bitexec_pkg::st_exec;
          end
        default: cur_next.pslverr = 1'b1;
      endcase
    end

    unique case (cur_reg.state)
      bitexec_pkg::st_idle: begin
        cur_next.cycle_cnt = 2'h0;
      end
      bitexec_pkg::st_exec: begin
        cur_next.last_cycles = `CYC_SINGLE;
        cur_next.state = bitexec_pkg::st_idle;
        if (br_is_branch) begin
          // a taken branch costs a second cycle, fall-through costs one
          cur_next.pc = 16'(cur_reg.pc + 16'h0001);
          if (br_taken) begin
            cur_next.pc = branch_target(cur_reg.pc, cur_reg.offset_k);
            cur_next.last_cycles = `CYC_BRANCH_TAKEN;
            cur_next.state = bitexec_pkg::st_wait;
          end
        end else begin
          cur_next.pc = 16'(cur_reg.pc + 16'h0001);
          unique case (cur_reg.op)
            bitexec_pkg::io_bit_set_op, bitexec_pkg::io_bit_clear_op: begin
              io_we = 1'b1;
              io_wdata = put_bit(io_val, cur_reg.bit_b,
                cur_reg.op == bitexec_pkg::io_bit_set_op);
              cur_next.last_cycles = `CYC_IO_BIT;
              cur_next.state = bitexec_pkg::st_wait;
            end
            bitexec_pkg::shift_left_logical, bitexec_pkg::shift_right_logical,
            bitexec_pkg::rotate_left_via_carry, bitexec_pkg::rotate_right_via_carry,
            bitexec_pkg::shift_right_arith: begin
              cur_next.data = shift_result;
              cur_next.flags = shift_flags;
            end
            bitexec_pkg::nibble_exchange_op:
              cur_next.data = {cur_reg.data[3:0], cur_reg.data[7:4]};
            bitexec_pkg::store_bit_to_transfer:
              cur_next.flags[`FLAG_T] = cur_reg.data[cur_reg.bit_b];
            bitexec_pkg::load_bit_from_transfer:
              cur_next.data = put_bit(cur_reg.data, cur_reg.bit_b,
                                      cur_reg.flags[`FLAG_T]);
            bitexec_pkg::status_bit_set_op, bitexec_pkg::carry_flag_set_op,
            bitexec_pkg::negative_flag_set_op, bitexec_pkg::zero_flag_set_op,
            bitexec_pkg::global_irq_on_op:
              cur_next.flags[flag_index(cur_reg.op, cur_reg.bit_b)] = 1'b1;
            bitexec_pkg::status_bit_clear_op, bitexec_pkg::carry_flag_clear_op,
            bitexec_pkg::negative_flag_clear_op, bitexec_pkg::zero_flag_clear_op:
              cur_next.flags[flag_index(cur_reg.op, cur_reg.bit_b)] = 1'b0;
            default: cur_next.last_cycles = `CYC_SINGLE;
          endcase
        end
        if (cur_next.state == bitexec_pkg::st_idle) begin
          cur_next.busy = 1'b0;
          cur_next.done = 1'b1;
        end
      end
      bitexec_pkg::st_wait: begin
        cur_next.state = bitexec_pkg::st_idle;
        cur_next.busy = 1'b0;
        cur_next.done = 1'b1;
      end
    endcase

    if (!reset_n) begin
      cur_next.state = bitexec_pkg::st_idle;
      cur_next.op = bitexec_pkg::op_nop;
      cur_next.offset_k = 8'h00;
      cur_next.bit_b = 3'h0;
      cur_next.io_addr = 6'h00;
      cur_next.data = 8'h00;
      cur_next.flags = `FLAGS_RESET;
      cur_next.pc = 16'h0000;
      io_we = 1'b0;
      cur_next.cycle_cnt = 2'h0;
      cur_next.last_cycles = 2'h0;
      cur_next.busy = 1'b0;
      cur_next.done = 1'b0;
      cur_next.prdata = 32'h0;
      cur_next.pready = 1'b0;
      cur_next.pslverr = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    cur_reg <= cur_next;
    if (!reset_n) begin
      for (int i = 0; i < 64; i++) begin
        io_space[i] <= 8'h00;
      end
    end else if (io_we) begin
      io_space[cur_reg.io_addr] <= io_wdata;
    end
  end

  always_comb begin
    prdata = cur_reg.prdata;
    pready = cur_reg.pready;
    pslverr = cur_reg.pslverr;
  end

endmodule

// ---- core/branch_unit.sv ----
`timescale 1ns/1ps
`include "bitexec_cfg.svh"

module branch_unit (
  input wire bitexec_pkg::opcode_e op,
  input wire logic [7:0] flags,
  output logic is_branch,
  output logic taken
);
  logic sign_lt;

  always_comb begin
    sign_lt = flags[`FLAG_N] ^ flags[`FLAG_V];
    is_branch = 1'b1;
    taken = 1'b0;
    unique case (op)
      bitexec_pkg::branch_same_or_higher: taken = ~flags[`FLAG_C];
      bitexec_pkg::branch_unsigned_below: taken = flags[`FLAG_C];
      bitexec_pkg::branch_on_negative: taken = flags[`FLAG_N];
      bitexec_pkg::branch_on_positive: taken = ~flags[`FLAG_N];
      bitexec_pkg::branch_signed_ge: taken = ~sign_lt;
      bitexec_pkg::branch_signed_less: taken = sign_lt;
      bitexec_pkg::branch_half_carry_on: taken = flags[`FLAG_H];
      bitexec_pkg::branch_half_carry_off: taken = ~flags[`FLAG_H];
      bitexec_pkg::branch_transfer_on: taken = flags[`FLAG_T];
      bitexec_pkg::branch_irq_on: taken = flags[`FLAG_I];
      bitexec_pkg::branch_irq_off: taken = ~flags[`FLAG_I];
      default: is_branch = 1'b0;
    endcase
  end
endmodule

// ---- core/shift_unit.sv ----
`timescale 1ns/1ps
`include "bitexec_cfg.svh"

module shift_unit (
  input wire bitexec_pkg::opcode_e op,
  input wire logic [7:0] value,
  input wire logic [7:0] flags_in,
  output logic [7:0] result,
  output logic [7:0] flags_out
);
  logic carry_out;
  logic n_bit;

  always_comb begin
    result = value;
    carry_out = flags_in[`FLAG_C];
    unique case (op)
      bitexec_pkg::shift_left_logical: begin
        result = {value[6:0], 1'b0};
        carry_out = value[7];
      end
      bitexec_pkg::shift_right_logical: begin
        result = {1'b0, value[7:1]};
        carry_out = value[0];
      end
      bitexec_pkg::rotate_left_via_carry: begin
        result = {value[6:0], flags_in[`FLAG_C]};
        carry_out = value[7];
      end
      bitexec_pkg::rotate_right_via_carry: begin
        result = {flags_in[`FLAG_C], value[7:1]};
        carry_out = value[0];
      end
      bitexec_pkg::shift_right_arith: begin
        result = {value[7], value[7:1]};
        carry_out = value[0];
      end
      default: begin
        result = value;
        carry_out = flags_in[`FLAG_C];
      end
    endcase
    n_bit = result[7];
    flags_out = flags_in;
    flags_out[`FLAG_C] = carry_out;
    flags_out[`FLAG_Z] = (result == 8'h00);
    flags_out[`FLAG_N] = n_bit;
    // overflow follows the shift convention: sign xor carry out
    flags_out[`FLAG_V] = n_bit ^ carry_out;
    flags_out[`FLAG_S] = n_bit ^ (n_bit ^ carry_out);
  end
endmodule

// ---- sim/bit_exec_core_asserts.sv ----
`timescale 1ns/1ps
`include "bitexec_cfg.svh"
module bit_exec_core_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // --------------------------------
  // bus and status checks
  // --------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic mapped;
  logic st_rd;
  // eight aligned words from 0x00 up form the whole map
  assign mapped = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0;
  assign st_rd = pready && !pwrite && paddr == `REG_STATUS_ADDR;
  AST_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  AST_ERR_UNMAPPED: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  AST_ERR_MAPPED: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_STATUS_CYCLES: assert property (st_rd && prdata[1] |-> prdata[3:2] inside {2'h1, 2'h2})
    else $error("op took other than one or two cycles");
  AST_FLAGS_BYTE: assert property (
    pready && !pwrite && paddr == `REG_FLAGS_ADDR |-> prdata[31:8] == 24'h000000)
    else $error("flag word has upper bits set");
  cover property (pready && pslverr);
  cover property (st_rd && prdata[3:2] == 2'h2);
  cover property (st_rd && prdata[3:2] == 2'h1);
endmodule

bind bit_exec_core bit_exec_core_asserts i_bit_exec_core_asserts (.sys_clk(sys_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ---- sim/bit_exec_core_tb.sv ----
`timescale 1ns/1ps
`include "bitexec_cfg.svh"
module bit_exec_core_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd, st, rdd, rdf, rdp, rdi;
  logic err;
  int n_mismatch = 0;
  int cmp_count = 0;
  int fbit[7] = '{0, 0, 2, 2, 1, 1, 7};
  logic [7:0] fpat[4] = '{8'h00, 8'hFF, 8'h04, 8'h08};
  logic [7:0] dpat[3] = '{8'h81, 8'h00, 8'h40};

  bit_exec_core i_bit_exec_core (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // --------------------------------
  // bus tasks
  // --------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    if (t >= 20) begin
      n_mismatch++;
      $display("wrong value at %0t: no ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic run(input int op, input logic [31:0] opnd, input logic [7:0] d,
                     input logic [7:0] f, input logic [7:0] io);
    int t;
    apb(1'b1, `REG_OP_ADDR, 32'(op));
    apb(1'b1, `REG_OPERAND_ADDR, opnd);
    apb(1'b1, `REG_IO_ADDR, {24'h000000, io});
    apb(1'b1, `REG_DATA_ADDR, {24'h000000, d});
    apb(1'b1, `REG_FLAGS_ADDR, {24'h000000, f});
    apb(1'b1, `REG_PC_ADDR, 32'h00000100);
    apb(1'b1, `REG_STATUS_ADDR, 32'h00000000);
    apb(1'b1, `REG_GO_ADDR, 32'h00000001);
    t = 0;
    do begin
      apb(1'b0, `REG_STATUS_ADDR, 32'h00000000);
      t++;
    end while (rd[1] !== 1'b1 && t < 10);
    if (rd[1] !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: op never done", $time);
    end
    st = rd;
    apb(1'b0, `REG_DATA_ADDR, 32'h00000000);
    rdd = rd;
    apb(1'b0, `REG_FLAGS_ADDR, 32'h00000000);
    rdf = rd;
    apb(1'b0, `REG_PC_ADDR, 32'h00000000);
    rdp = rd;
    apb(1'b0, `REG_IO_ADDR, 32'h00000000);
    rdi = rd;
  endtask

  // --------------------------------
  // expected behaviour
  // --------------------------------
  function automatic logic taken(input int op, input logic [7:0] f);
    case (op)
      1: return !f[0];
      2: return f[0];
      3: return f[2];
      4: return !f[2];
      5: return !(f[2] ^ f[3]);
      6: return f[2] ^ f[3];
      7: return f[5];
      8: return !f[5];
      9: return f[6];
      10: return f[7];
      default: return !f[7];
    endcase
  endfunction

  function automatic logic [15:0] shifted(input int op, input logic [7:0] d, input logic [7:0] f);
    logic [7:0] r;
    logic c, n, v;
    case (op)
      14: {c, r} = {d, 1'b0};
      15: {r, c} = {1'b0, d};
      16: {c, r} = {d, f[0]};
      17: {r, c} = {f[0], d};
      18: {r, c} = {d[7], d};
      default: return {f, d[3:0], d[7:4]};
    endcase
    n = r[7];
    v = n ^ c;
    return {f[7:5], n ^ v, v, n, r == 8'h00, c, r};
  endfunction

  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    logic [15:0] e, epc;
    logic [7:0] k;
    logic tk;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, `REG_FLAGS_ADDR, 32'h00000000);
    chk(rd[15:0], 16'h0000);
    apb(1'b0, 12'h020, 32'h00000000);
    chk(16'(err), 16'h0001);
    for (int op = 1; op <= 11; op++) begin
      for (int j = 0; j < 4; j++) begin
        k = j[0] ? 8'hFD : 8'h05;
        tk = taken(op, fpat[j]);
        epc = tk ? 16'h0101 + {{8{k[7]}}, k} : 16'h0101;
        run(op, {24'h000000, k}, 8'h5A, fpat[j], 8'h00);
        chk(rdp[15:0], epc);
        chk(16'(st[3:2]), tk ? 16'h0002 : 16'h0001);
        chk(rdf[15:0], {8'h00, fpat[j]});
      end
    end
    for (int op = 14; op <= 19; op++) begin
      for (int i = 0; i < 6; i++) begin
        run(op, 32'h00000000, dpat[i % 3], i < 3 ? 8'h00 : 8'hE1, 8'h00);
        e = shifted(op, dpat[i % 3], i < 3 ? 8'h00 : 8'hE1);
        chk({rdf[7:0], rdd[7:0]}, e);
        chk(16'(st[3:2]), 16'h0001);
      end
    end
    for (int s = 0; s < 8; s++) begin
      run(20, 32'(s) << 8, 8'h00, 8'h00, 8'h00);
      chk(rdf[15:0], 16'h0001 << s);
      run(21, 32'(s) << 8, 8'h00, 8'hFF, 8'h00);
      chk(rdf[15:0], {8'h00, ~(8'h01 << s)});
    end
    for (int i = 0; i < 7; i++) begin
      run(24 + i, 32'h00000000, 8'h00, i[0] ? 8'hFF : 8'h00, 8'h00);
      chk(rdf[15:0], i[0] ? {8'h00, ~(8'h01 << fbit[i])} : 16'h0001 << fbit[i]);
    end
    run(22, 32'h00000500, 8'h20, 8'h00, 8'h00);
    chk({rdf[7:0], rdd[7:0]}, 16'h4020);
    run(22, 32'h00000400, 8'h20, 8'hFF, 8'h00);
    chk(rdf[15:0], 16'h00BF);
    run(23, 32'h00000300, 8'h00, 8'h40, 8'h00);
    chk({rdf[7:0], rdd[7:0]}, 16'h4008);
    run(23, 32'h00000300, 8'hFF, 8'h00, 8'h00);
    chk({rdf[7:0], rdd[7:0]}, 16'h00F7);
    run(12, 32'h00015600, 8'h00, 8'hE5, 8'h00);
    chk({rdf[7:0], rdi[7:0]}, 16'hE540);
    chk(16'(st[3:2]), 16'h0002);
    run(13, 32'h00015600, 8'h00, 8'h1A, 8'hFF);
    chk({rdf[7:0], rdi[7:0]}, 16'h1ABF);
    chk(16'(st[3:2]), 16'h0002);
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
